/* hdl/bpm_map.svh */
/*
  Offsets, field positions, codes and timing counts of the battery
  power-mode sequencer. Assumes register indices scale by four on APB.
*/
`ifndef BPM_MAP_SVH
`define BPM_MAP_SVH
// What this block does
// - In display-only mode keep PLL running only when boost setting is 10.
// - Brownout entry leaves PLL frequency as in normal mode.
// - Clock control bit 4 selects PLL speed, bits 2:0 divide CPU clock.
// - Power returning during brownout moves to normal mode automatically.
// - From brownout firmware may request display-only or sleep mode.
// - Writing display-only request bit 6 enters display-only from normal or brownout mode.
// - Display-only requested with power present wakes again at once.
// - Display-only drives segments from stored data; two segments may blink.
// - Leaving display-only restarts CPU, resets volatile bits, RAM undefined.
// - Sleep request bit 7 without system power enters sleep.
// - Sleep keeps configuration and leaves only on power-up or wake.
// - Sleep requested with power present drops wake then wakes at once.
// - Leaving sleep restarts CPU, keeps non-volatile bits, RAM undefined.
// - Higher threshold crossed shows status 001 and only warns.
// - Lower threshold crossed switches supply to battery.
// - Status code sits in bits 2:0 of register 0xF9, read-only.
// - Status 000 good, 010 battery good core, 011 marginal, flash inhibited.
// - Core below minimum shows 101, CPU reset four crystal cycles later.
// - Lower comparator good always switches back to system supply.
// - Automatic switch to battery raises an interrupt.
// - Below lower threshold converter clocks stop, control bits unchanged.
// - System power gone forces brownout while the CPU keeps running.
// - Wake events return display-only or sleep to brownout.
`define BPM_IDX_STATUS 14'h00f9
`define BPM_IDX_CLKCTL 14'h2200
`define BPM_IDX_MODEREQ 14'h28b2
`define BPM_IDX_DISPCFG 14'h2401
`define BPM_IDX_SEGDATA 14'h2410
`define BPM_PLL_FAST_BIT 4
`define BPM_DIV_MSB 2
`define BPM_DISP_REQ_BIT 6
`define BPM_SLEEP_REQ_BIT 7
`define BPM_BOOST_MSB 7
`define BPM_BOOST_LSB 6
`define BPM_BOOST_KEEP 2'h2
`define BPM_CLKCTL_RST 8'h10
`define BPM_DISPCFG_RST 8'h00
`define BPM_VS_GOOD 3'h0
`define BPM_VS_LOW 3'h1
`define BPM_VS_BATT 3'h2
`define BPM_VS_MARG 3'h3
`define BPM_VS_BAD 3'h5
`define BPM_BADVDD_TICKS 4
`define BPM_XTAL_HZ 32768
`define BPM_BLINK_MS 500
`endif

/* hdl/bpm_pkg.sv */
/*
  Types of the battery power-mode sequencer.
  Assumes nothing of its surroundings.
*/
package bpm_pkg;
  typedef enum logic [1:0] {normal_mode, brownout_mode, display_only, sleep_mode_state}
    bpm_mode_type;
  typedef logic [2:0] bpm_status_type;
endpackage

/* hdl/bpm_sync.sv */
/*
  Two-flop synchroniser for a group of asynchronous levels.
  Assumes inputs are slow levels.
*/
module bpm_sync import bpm_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;

  if (W < 1) begin : g_chk
    $error("bpm_sync needs W of at least one");
  end

  // Reset value matches the idle level of each input
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= RST;
      dout <= RST;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // bpm_sync

/* hdl/bpm_tick_count.sv */
/*
  Counts crystal ticks while enabled; done stays high once N reached, until run falls.
  Assumes tick is a one-cycle pulse on mclk.
*/
module bpm_tick_count import bpm_pkg::*; #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Control
  input wire logic run,
  input wire logic tick,
  output logic done
);
  localparam int CW = $clog2(N + 1);
  logic [CW-1:0] cnt_r;

  if (N < 1) begin : g_chk
    $error("bpm_tick_count needs N of at least one");
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
      done <= 1'b0;
    end else if (!run) begin
      cnt_r <= '0;
      done <= 1'b0;
    end else if (tick && !done) begin
      cnt_r <= cnt_r + 1'b1;
      done <= (cnt_r == CW'(N - 1));
    end
  end
endmodule // bpm_tick_count

/* hdl/bpm_sequencer.sv */
/*
  Battery power-mode sequencer with APB register access.
  Assumes comparator, wake and crystal inputs are asynchronous levels;
  mclk runs at 250 MHz from reset onward.
*/
// The APB slave port was left to the implementer.
`include "bpm_map.svh"
module bpm_sequencer import bpm_pkg::*; #(
  parameter int BLINK_TICKS = `BPM_XTAL_HZ * `BPM_BLINK_MS / 1000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply monitors and wake sources
  input wire logic supply_high_ok,
  input wire logic supply_low_ok,
  input wire logic core_ok,
  input wire logic core_min_ok,
  input wire logic crystal_clock,
  input wire logic wake_event,
  // Power control
  output logic [1:0] mode_out,
  output logic battery_select,
  output logic pll_enable,
  output logic pll_fast,
  output logic [2:0] cpu_clock_divider,
  output logic converter_clk_en,
  output logic flash_write_inhibit,
  output logic power_irq,
  // Processor control
  output logic cpu_reset,
  output logic cpu_wake,
  output logic volatile_reset,
  output logic external_data_ram_invalid,
  // Display
  output logic [7:0] segment_out,
  output logic [1:0] blink_out
);

  if (BLINK_TICKS < 2) begin : g_chk
    $error("BLINK_TICKS must be at least two");
  end

  logic high_s, low_s, core_s, coremin_s, xtal_s, wake_s;
  logic xtal_d_r;
  logic xtal_tick;
  bpm_mode_type mode_r, mode_nxt;
  bpm_status_type status_r, status_nxt;
  logic [7:0] clk_ctrl_r;
  logic [7:0] disp_cfg_r;
  logic [7:0] seg_r;
  logic disp_req_r, sleep_req_r;
  logic wr_en, setup;
  logic [13:0] idx;
  logic dormant, leaving, badvdd_done, blink_done;
  logic [1:0] blink_ph_r;

  // Supply flags reset high so no false fault follows reset
  bpm_sync #(.W(6), .RST(6'h3c)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .din({supply_high_ok, supply_low_ok, core_ok, core_min_ok, crystal_clock, wake_event}),
    .dout({high_s, low_s, core_s, coremin_s, xtal_s, wake_s})
  );

  // Crystal edge gives the state step
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      xtal_d_r <= 1'b0;
    end else begin
      xtal_d_r <= xtal_s;
    end
  end
  assign xtal_tick = xtal_s && !xtal_d_r;

  // Power status decode
  always_comb begin
    if (high_s) begin
      status_nxt = `BPM_VS_GOOD;
    end else if (low_s) begin
      status_nxt = `BPM_VS_LOW;
    end else if (core_s) begin
      status_nxt = `BPM_VS_BATT;
    end else if (coremin_s) begin
      status_nxt = `BPM_VS_MARG;
    end else begin
      status_nxt = `BPM_VS_BAD;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= `BPM_VS_GOOD;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Mode sequence
  always_comb begin
    mode_nxt = mode_r;
    if (xtal_tick) begin
      case (mode_r)
        normal_mode: begin
          if (disp_req_r) begin
            mode_nxt = display_only;
          end else if (sleep_req_r) begin
            mode_nxt = sleep_mode_state;
          end else if (!low_s) begin
            mode_nxt = brownout_mode;
          end
        end
        brownout_mode: begin
          if (low_s) begin
            mode_nxt = normal_mode;
          end else if (disp_req_r) begin
            mode_nxt = display_only;
          end else if (sleep_req_r) begin
            mode_nxt = sleep_mode_state;
          end
        end
        display_only, sleep_mode_state: begin
          if (low_s) begin
            mode_nxt = normal_mode;
          end else if (wake_s) begin
            mode_nxt = brownout_mode;
          end
        end
        default: mode_nxt = normal_mode;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= normal_mode;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign dormant = (mode_r == display_only) || (mode_r == sleep_mode_state);
  assign leaving = dormant && (mode_nxt != display_only) && (mode_nxt != sleep_mode_state);

  // APB decode; zero wait, answer one cycle after setup
  assign idx = paddr[15:2];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (setup) begin
        case (idx)
          `BPM_IDX_STATUS: prdata <= {29'h0, status_r};
          `BPM_IDX_CLKCTL: prdata <= {24'h0, clk_ctrl_r};
          `BPM_IDX_MODEREQ: prdata <= {24'h0, sleep_req_r, disp_req_r, 6'h0};
          `BPM_IDX_DISPCFG: prdata <= {24'h0, disp_cfg_r};
          `BPM_IDX_SEGDATA: prdata <= {24'h0, seg_r};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Volatile configuration, cleared on display-only exit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clk_ctrl_r <= `BPM_CLKCTL_RST;
      disp_cfg_r <= `BPM_DISPCFG_RST;
    end else if (leaving && mode_r == display_only) begin
      clk_ctrl_r <= `BPM_CLKCTL_RST;
      disp_cfg_r <= `BPM_DISPCFG_RST;
    end else if (wr_en && idx == `BPM_IDX_CLKCTL) begin
      clk_ctrl_r <= pwdata[7:0];
    end else if (wr_en && idx == `BPM_IDX_DISPCFG) begin
      disp_cfg_r <= pwdata[7:0];
    end
  end

  // Segment data survives every mode
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      seg_r <= 8'h00;
    end else if (wr_en && idx == `BPM_IDX_SEGDATA) begin
      seg_r <= pwdata[7:0];
    end
  end

  // Requests: a new write wins over the clear on entry
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      disp_req_r <= 1'b0;
      sleep_req_r <= 1'b0;
    end else begin
      if (wr_en && idx == `BPM_IDX_MODEREQ && pwdata[`BPM_DISP_REQ_BIT]) begin
        disp_req_r <= 1'b1;
      end else if (mode_nxt == display_only && mode_r != display_only) begin
        disp_req_r <= 1'b0;
      end
      if (wr_en && idx == `BPM_IDX_MODEREQ && pwdata[`BPM_SLEEP_REQ_BIT]) begin
        sleep_req_r <= 1'b1;
      end else if (mode_nxt == sleep_mode_state && mode_r != sleep_mode_state) begin
        sleep_req_r <= 1'b0;
      end
    end
  end

  // Core undervoltage reset after four crystal cycles
  bpm_tick_count #(.N(`BPM_BADVDD_TICKS)) u_badvdd (
    .mclk(mclk),
    .reset_n(reset_n),
    .run(status_r == `BPM_VS_BAD && !dormant && !sleep_req_r),
    .tick(xtal_tick),
    .done(badvdd_done)
  );

  // Blink half period in crystal ticks
  bpm_tick_count #(.N(BLINK_TICKS)) u_blink (
    .mclk(mclk),
    .reset_n(reset_n),
    .run(mode_r == display_only && !blink_done),
    .tick(xtal_tick),
    .done(blink_done)
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      blink_ph_r <= 2'h0;
    end else if (mode_r != display_only) begin
      blink_ph_r <= 2'h0;
    end else if (blink_done) begin
      blink_ph_r <= ~blink_ph_r;
    end
  end

  // Registered power and processor controls
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_out <= 2'h0;
      battery_select <= 1'b0;
      pll_enable <= 1'b1;
      pll_fast <= 1'b0;
      cpu_clock_divider <= 3'h0;
      converter_clk_en <= 1'b0;
      flash_write_inhibit <= 1'b0;
      power_irq <= 1'b0;
      cpu_reset <= 1'b0;
      cpu_wake <= 1'b1;
      volatile_reset <= 1'b0;
      external_data_ram_invalid <= 1'b0;
      segment_out <= 8'h00;
      blink_out <= 2'h0;
    end else begin
      mode_out <= mode_r;
      battery_select <= !low_s;
      pll_enable <= (mode_r == normal_mode) || (mode_r == brownout_mode) ||
        (mode_r == display_only &&
         disp_cfg_r[`BPM_BOOST_MSB:`BPM_BOOST_LSB] == `BPM_BOOST_KEEP);
      pll_fast <= clk_ctrl_r[`BPM_PLL_FAST_BIT];
      cpu_clock_divider <= clk_ctrl_r[`BPM_DIV_MSB:0];
      converter_clk_en <= low_s;
      flash_write_inhibit <= status_r == `BPM_VS_MARG || status_r == `BPM_VS_BAD;
      power_irq <= xtal_tick && mode_r == normal_mode &&
        mode_nxt == brownout_mode;
      cpu_reset <= dormant || badvdd_done || leaving;
      cpu_wake <= !dormant;
      volatile_reset <= leaving && mode_r == display_only;
      external_data_ram_invalid <= leaving;
      segment_out <= seg_r;
      blink_out <= disp_cfg_r[1:0] & blink_ph_r;
    end
  end

  pll_keep_a: assert property (@(posedge mclk) disable iff (!reset_n)
    mode_r == display_only && disp_cfg_r[7:6] == 2'h2 |=> pll_enable)
    else $error("PLL dropped in display-only with boost");
  pll_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
    mode_r == display_only && disp_cfg_r[7:6] != 2'h2 |=> !pll_enable)
    else $error("PLL left running in display-only");
  pll_speed_a: assert property (@(posedge mclk) disable iff (!reset_n)
    mode_r == brownout_mode |=> pll_fast == $past(clk_ctrl_r[4]))
    else $error("PLL speed changed in brownout");
  auto_return_a: assert property (@(posedge mclk) disable iff (!reset_n)
    mode_r == brownout_mode && low_s && xtal_tick |=> mode_r == normal_mode)
    else $error("No return to normal mode");
  disp_enter_a: assert property (@(posedge mclk) disable iff (!reset_n)
    mode_r == brownout_mode && !low_s && disp_req_r && xtal_tick
    |=> mode_r == display_only)
    else $error("Display-only request not taken");
  quick_wake_a: assert property (@(posedge mclk) disable iff (!reset_n)
    dormant && low_s && xtal_tick |=> mode_r == normal_mode ##1 cpu_wake)
    else $error("No immediate wake with power present");
  warn_code_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !high_s && low_s |=> status_r == 3'h1)
    else $error("Warning code wrong");
  batt_switch_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !low_s |=> battery_select)
    else $error("Battery supply not selected");
  bad_reset_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(badvdd_done) |-> status_r == 3'h5 ##1 cpu_reset)
    else $error("Undervoltage reset out of place");
  batt_irq_a: assert property (@(posedge mclk) disable iff (!reset_n)
    mode_r == normal_mode ##1 mode_r == brownout_mode |-> power_irq)
    else $error("No interrupt on battery switch");
  wake_exit_a: assert property (@(posedge mclk) disable iff (!reset_n)
    dormant && !low_s && wake_s && xtal_tick
    |=> mode_r == brownout_mode && external_data_ram_invalid ##1 !external_data_ram_invalid)
    else $error("Wake event not honoured");
  sleep_enter_a: assert property (@(posedge mclk) disable iff (!reset_n)
    mode_r == brownout_mode && !low_s && !disp_req_r && sleep_req_r && xtal_tick
    |=> mode_r == sleep_mode_state)
    else $error("Sleep request not taken");
  seg_drive_a: assert property (@(posedge mclk) disable iff (!reset_n)
    mode_r == display_only |=> segment_out == $past(seg_r))
    else $error("Segment pins not driven from stored data");
  vol_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
    leaving && mode_r == display_only
    |=> clk_ctrl_r == 8'h10 && disp_cfg_r == 8'h00 && volatile_reset && cpu_reset)
    else $error("Volatile bits kept on display-only exit");
  sleep_keep_a: assert property (@(posedge mclk) disable iff (!reset_n)
    leaving && mode_r == sleep_mode_state && !wr_en
    |=> clk_ctrl_r == $past(clk_ctrl_r) && disp_cfg_r == $past(disp_cfg_r) && external_data_ram_invalid)
    else $error("Configuration lost on sleep exit");
  status_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
    setup && idx == `BPM_IDX_STATUS |=> prdata == {29'h0, $past(status_r)})
    else $error("Status read wrong");
  flash_block_a: assert property (@(posedge mclk) disable iff (!reset_n)
    status_r == 3'h3 |=> flash_write_inhibit)
    else $error("Flash write not inhibited");
  conv_stop_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !low_s |=> !converter_clk_en)
    else $error("Converter clock left running");
endmodule // bpm_sequencer

/* sim/battery_power_mode_sequencer_bench.sv */
/*
  Self-checking bench of the battery power-mode sequencer: APB register
  access, supply status codes, mode changes, wake and display paths.
  Assumes the design files under hdl/ and bpm_map.svh on the include path.
*/
`include "bpm_map.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module battery_power_mode_sequencer_bench import bpm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] a_status = {`BPM_IDX_STATUS, 2'b00};
  localparam logic [15:0] a_clk = {`BPM_IDX_CLKCTL, 2'b00};
  localparam logic [15:0] a_req = {`BPM_IDX_MODEREQ, 2'b00};
  localparam logic [15:0] a_disp = {`BPM_IDX_DISPCFG, 2'b00};
  localparam logic [15:0] a_seg = {`BPM_IDX_SEGDATA, 2'b00};
  logic mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic supply_high_ok = 1'b1, supply_low_ok = 1'b1, core_ok = 1'b1, core_min_ok = 1'b1;
  logic crystal_clock = 1'b0, wake_event = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, battery_select, pll_enable, pll_fast, converter_clk_en;
  logic flash_write_inhibit, power_irq, cpu_reset, cpu_wake, volatile_reset, external_data_ram_invalid;
  logic [1:0] mode_out, blink_out;
  logic [2:0] cpu_clock_divider;
  logic [7:0] segment_out, seg_v;
  logic [1:0] blink_prev = 2'h0;
  logic [32:0] exp_q[$];
  logic [32:0] exp_v;
  logic [31:0] seed = 32'hbd4a_a0b0;
  int bad_count = 0, comparisons = 0, irq_n = 0, vr_n = 0, xi_n = 0, xc_cnt = 0, blink_n = 0;

  bpm_sequencer #(.BLINK_TICKS(4)) u_dut (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_high_ok(supply_high_ok), .supply_low_ok(supply_low_ok), .core_ok(core_ok),
    .core_min_ok(core_min_ok), .crystal_clock(crystal_clock), .wake_event(wake_event),
    .mode_out(mode_out), .battery_select(battery_select), .pll_enable(pll_enable),
    .pll_fast(pll_fast), .cpu_clock_divider(cpu_clock_divider),
    .converter_clk_en(converter_clk_en), .flash_write_inhibit(flash_write_inhibit),
    .power_irq(power_irq), .cpu_reset(cpu_reset), .cpu_wake(cpu_wake),
    .volatile_reset(volatile_reset), .external_data_ram_invalid(external_data_ram_invalid),
    .segment_out(segment_out), .blink_out(blink_out)
  );

  initial begin
    forever #2 mclk = ~mclk;
  end

  // Fast crystal stand-in: one tick every 40 mclk
  always @(posedge mclk) begin
    if (xc_cnt == 19) begin
      xc_cnt <= 0;
      crystal_clock <= ~crystal_clock;
    end else begin
      xc_cnt <= xc_cnt + 1;
    end
  end

  // Pulse counters and read-data checker
  always @(posedge mclk) begin
    if (power_irq === 1'b1) irq_n++;
    if (volatile_reset === 1'b1) vr_n++;
    if (external_data_ram_invalid === 1'b1) xi_n++;
    if (blink_out === 2'h3 && blink_prev !== 2'h3) blink_n++;
    blink_prev = blink_out;
    if (pready === 1'b1 && pwrite === 1'b0) begin
      exp_v = exp_q.pop_front();
      `CHK({pslverr, prdata}, exp_v)
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_sim;
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic is_wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic err);
    exp_q.push_back({err, 24'h00_0000, d});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic sup(input logic h, input logic l, input logic c, input logic m);
    @(posedge mclk);
    supply_high_ok <= h;
    supply_low_ok <= l;
    core_ok <= c;
    core_min_ok <= m;
    repeat (8) @(posedge mclk);
  endtask

  task automatic wait_mode(input bpm_mode_type m);
    int n;
    n = 0;
    while (mode_out !== m && n < 300) begin
      @(posedge mclk);
      n++;
    end
    repeat (2) @(posedge mclk);
  endtask

  task automatic wake;
    @(posedge mclk);
    wake_event <= 1'b1;
    wait_mode(brownout_mode);
    wake_event <= 1'b0;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    rd(a_clk, 8'h10, 1'b0);
    rd(a_status, 8'h00, 1'b0);
    rd(16'h0004, 8'h00, 1'b1);
    wr(a_status, 8'hff);
    rd(a_status, 8'h00, 1'b0);
    wr(a_clk, 8'h24);
    rd(a_clk, 8'h24, 1'b0);
    `CHK({pll_fast, cpu_clock_divider}, 4'h4)
    wr(a_req, 8'h40);
    wait_mode(display_only);
    `CHK(mode_out, display_only)
    wait_mode(normal_mode);
    `CHK(mode_out, normal_mode)
    `CHK(vr_n, 1)
    rd(a_clk, 8'h10, 1'b0);
    wr(a_req, 8'h80);
    wait_mode(sleep_mode_state);
    `CHK(cpu_wake, 1'b0)
    wait_mode(normal_mode);
    `CHK({mode_out, cpu_wake}, {normal_mode, 1'b1})
    rd(a_req, 8'h00, 1'b0);
    wr(a_clk, 8'h24);
    sup(1'b0, 1'b1, 1'b1, 1'b1);
    rd(a_status, 8'h01, 1'b0);
    `CHK({mode_out, battery_select, irq_n}, {normal_mode, 1'b0, 32'd0})
    sup(1'b0, 1'b0, 1'b1, 1'b1);
    wait_mode(brownout_mode);
    rd(a_status, 8'h02, 1'b0);
    `CHK({battery_select, converter_clk_en, irq_n}, {1'b1, 1'b0, 32'd1})
    `CHK({mode_out, pll_enable, pll_fast}, {brownout_mode, 2'b10})
    sup(1'b0, 1'b0, 1'b0, 1'b1);
    rd(a_status, 8'h03, 1'b0);
    `CHK(flash_write_inhibit, 1'b1)
    sup(1'b0, 1'b0, 1'b0, 1'b0);
    rd(a_status, 8'h05, 1'b0);
    repeat (60) @(posedge mclk);
    `CHK(cpu_reset, 1'b0)
    repeat (180) @(posedge mclk);
    `CHK(cpu_reset, 1'b1)
    sup(1'b0, 1'b0, 1'b1, 1'b1);
    `CHK({cpu_reset, flash_write_inhibit}, 2'b00)
    seed = lfsr(seed);
    seg_v = seed[7:0];
    wr(a_seg, seg_v);
    wr(a_disp, 8'h83);
    wr(a_req, 8'h40);
    wait_mode(display_only);
    `CHK({mode_out, pll_enable, cpu_wake}, {display_only, 2'b10})
    `CHK(segment_out, seg_v)
    repeat (400) @(posedge mclk);
    `CHK(mode_out, display_only)
    // Half period of 4 ticks of 40 mclk gives one rise in this span
    `CHK(blink_n, 1)
    wake();
    `CHK(mode_out, brownout_mode)
    rd(a_disp, 8'h00, 1'b0);
    rd(a_seg, seg_v, 1'b0);
    wr(a_req, 8'h40);
    wait_mode(display_only);
    `CHK({pll_enable, cpu_reset}, 2'b01)
    wake();
    wr(a_clk, 8'h24);
    wr(a_req, 8'h80);
    wait_mode(sleep_mode_state);
    repeat (200) @(posedge mclk);
    `CHK({mode_out, cpu_wake}, {sleep_mode_state, 1'b0})
    wake();
    rd(a_clk, 8'h24, 1'b0);
    `CHK({vr_n, xi_n}, {32'd3, 32'd5})
    sup(1'b1, 1'b1, 1'b1, 1'b1);
    wait_mode(normal_mode);
    `CHK({mode_out, battery_select}, {normal_mode, 1'b0})
    rd(a_status, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(a_seg, seed[7:0]);
      rd(a_seg, seed[7:0], 1'b0);
    end
    end_sim();
  end
endmodule // battery_power_mode_sequencer_bench
